// [dv/periph_model.sv]
`timescale 1ns/1ps
module periph_model (
   input wire logic clk,
   input wire logic rd,
   input wire logic wr,
   input wire logic [7:0] addr,
   input wire logic alt,
   input wire logic [7:0] wdata,
   output logic [7:0] rdata
);
   logic [7:0] mem [0:511];
   initial for (int i = 0; i < 512; i++) mem[i] = 8'(i * 37 + 5);
   // Data only valid under the strobe
   assign rdata = rd ? mem[{alt, addr}] : ~mem[{alt, addr}];
   always @(posedge clk) if (wr) mem[{alt, addr}] <= wdata;
endmodule

// [dv/sfr_space_page_decoder_bench.sv]
`timescale 1ns/1ps
module sfr_space_page_decoder_bench;
   logic mclk, reset, acc_indirect, byte_rd, byte_wr, bit_rd, bit_wr, bit_val;
   logic [7:0] acc_addr, acc_wdata, per_rdata, rdata, per_addr, per_wdata;
   logic busy, rbit, rvalid, per_rd, per_wr, per_alt, page_now, unlocked;
   logic unocc_hit, v;
   logic [7:0] sh [0:511];
   logic [7:0] a, d, b;
   int error_cnt = 0;
   int total_checks = 0;
   sfr_space_page_decoder i_sfr_space_page_decoder (.MCLK(mclk),
      .RESET(reset), .ACC_ADDR(acc_addr), .ACC_INDIRECT(acc_indirect),
      .BYTE_RD(byte_rd), .BYTE_WR(byte_wr), .BIT_RD(bit_rd), .BIT_WR(bit_wr),
      .BIT_VAL(bit_val), .ACC_WDATA(acc_wdata), .PER_RDATA(per_rdata),
      .BUSY(busy), .RDATA(rdata), .RBIT(rbit), .RVALID(rvalid),
      .PER_RD(per_rd), .PER_WR(per_wr), .PER_ADDR(per_addr),
      .PER_ALT(per_alt), .PER_WDATA(per_wdata), .PAGE_NOW(page_now),
      .UNLOCKED(unlocked), .UNOCC_HIT(unocc_hit));
   periph_model i_periph_model (.clk(mclk), .rd(per_rd), .wr(per_wr),
      .addr(per_addr), .alt(per_alt), .wdata(per_wdata), .rdata(per_rdata));
   initial begin
      mclk = 1'b0;
      forever #2 mclk = ~mclk;
   end
   ////////////////////////////////////////////////////////////////////////////
   task automatic stop_test();
      $display("checks %0d errors %0d", total_checks, error_cnt);
      if (error_cnt == 0 && total_checks > 0) begin
         $display("TEST PASSED");
      end else begin
         $display("TEST FAILED");
      end
      $finish;
   endtask
   task automatic cmp8(input logic [7:0] g, input logic [7:0] e);
      total_checks++;
      if (g !== e) begin
         error_cnt++;
         $display("[FAIL] %0t byte %h exp %h", $time, g, e);
      end
   endtask
   task automatic cmp1(input logic g, input logic e);
      total_checks++;
      if (g !== e) begin
         error_cnt++;
         $display("[FAIL] %0t flag %b exp %b", $time, g, e);
      end
   endtask
   task automatic req(input logic [3:0] k, input logic [7:0] ad,
                      input logic [7:0] wd, input logic bv);
      @(posedge mclk);
      {byte_wr, byte_rd, bit_wr, bit_rd} <= k;
      acc_addr <= ad;
      acc_wdata <= wd;
      bit_val <= bv;
      @(posedge mclk);
      {byte_wr, byte_rd, bit_wr, bit_rd} <= 4'h0;
      acc_wdata <= ~wd;
      #1;
   endtask
   task automatic wr(input logic [7:0] ad, input logic [7:0] wd,
                     input logic s);
      req(4'h8, ad, wd, 1'b0);
      cmp1(per_wr, s);
   endtask
   task automatic rd(input logic [7:0] ad, input logic [7:0] e);
      req(4'h4, ad, 8'h00, 1'b0);
      @(posedge mclk);
      #1;
      cmp1(rvalid, 1'b1);
      cmp8(rdata, e);
   endtask
   task automatic unlock();
      wr(8'hC7, 8'hAA, 1'b0);
      wr(8'hC7, 8'h55, 1'b0);
   endtask
   function automatic logic [7:0] pick();
      logic [7:0] x;
      do x = 8'h80 | 8'($urandom);
      while (x inside {8'h84, 8'h85, 8'h9D, 8'h9E, 8'hA1, 8'hF1, 8'hFD,
                       8'h91, 8'hC7});
      return x;
   endfunction
   ////////////////////////////////////////////////////////////////////////////
   initial begin
      void'($urandom(32'hCB308EE1));
      reset = 1'b1;
      acc_indirect = 1'b0;
      {byte_wr, byte_rd, bit_wr, bit_rd} = 4'h0;
      acc_addr = 8'h80;
      acc_wdata = 8'h00;
      bit_val = 1'b0;
      for (int i = 0; i < 512; i++) sh[i] = 8'(i * 37 + 5);
      repeat (12) @(posedge mclk);
      reset <= 1'b0;
      #1;
      cmp1(page_now, 1'b0);
      rd(8'h91, 8'h00);
      repeat (20) begin
         a = pick();
         d = 8'($urandom);
         wr(a, d, 1'b1);
         sh[{1'b0, a}] = d;
         rd(a, d);
      end
      @(posedge mclk) acc_indirect <= 1'b1;
      wr(8'h80, 8'h3C, 1'b0);
      @(posedge mclk) acc_indirect <= 1'b0;
      wr(8'h10, 8'h3C, 1'b0);
      rd(8'h80, sh[9'h080]);
      for (int n = 0; n < 9; n++) begin
         b = (n == 8) ? 8'h8B : 8'h80 | 8'($urandom);
         v = 1'($urandom);
         req(4'h2, b, 8'h00, v);
         @(posedge mclk);
         #1;
         cmp1(per_wr, 1'b1);
         sh[{1'b0, b[7:3], 3'h0}][b[2:0]] = v;
         rd({b[7:3], 3'h0}, sh[{1'b0, b[7:3], 3'h0}]);
         req(4'h1, b ^ 8'h05, 8'h00, 1'b0);
         @(posedge mclk);
         #1;
         cmp1(rbit, sh[{1'b0, b[7:3], 3'h0}][b[2:0] ^ 3'h5]);
      end
      rd(8'h8B, sh[9'h08B]);
      cmp1(unlocked, 1'b0);
      wr(8'h91, 8'h01, 1'b0);
      @(posedge mclk);
      #1;
      cmp1(page_now, 1'b0);
      unlock();
      cmp1(unlocked, 1'b1);
      wr(8'h91, 8'h01, 1'b0);
      @(posedge mclk);
      #1;
      cmp1(page_now, 1'b1);
      rd(8'h91, 8'h01);
      rd(8'hB1, sh[9'h1B1]);
      rd(8'h80, sh[9'h080]);
      rd(8'hFE, 8'h00);
      unlock();
      repeat (6) @(posedge mclk);
      cmp1(unlocked, 1'b0);
      wr(8'h91, 8'hFE, 1'b0);
      @(posedge mclk);
      #1;
      cmp1(page_now, 1'b1);
      unlock();
      wr(8'h91, 8'hFE, 1'b0);
      cmp1(unlocked, 1'b0);
      @(posedge mclk);
      #1;
      cmp1(page_now, 1'b0);
      rd(8'hFE, sh[9'h0FE]);
      stop_test();
   end
   initial begin
      #80000;
      error_cnt++;
      $display("[FAIL] %0t watchdog expired", $time);
      stop_test();
   end
endmodule

// [dv/sfr_space_page_decoder_props.sv]
`timescale 1ns/1ps
module sfr_decoder_props (
   input wire logic MCLK,
   input wire logic RESET,
   input wire logic [7:0] ACC_ADDR,
   input wire logic ACC_INDIRECT,
   input wire logic BYTE_RD,
   input wire logic BYTE_WR,
   input wire logic BIT_RD,
   input wire logic BIT_WR,
   input wire logic BIT_VAL,
   input wire logic [7:0] ACC_WDATA,
   input wire logic [7:0] PER_RDATA,
   input wire logic BUSY,
   input wire logic RVALID,
   input wire logic PER_RD,
   input wire logic PER_WR,
   input wire logic [7:0] PER_ADDR,
   input wire logic PER_ALT,
   input wire logic [7:0] PER_WDATA,
   input wire logic PAGE_NOW,
   input wire logic UNLOCKED,
   input wire logic UNOCC_HIT
);
   default clocking @(posedge MCLK); endclocking
   default disable iff (RESET);
   wire req = BYTE_RD | BYTE_WR | BIT_RD | BIT_WR;
   wire take = req & ~BUSY & ACC_ADDR[7] & ~ACC_INDIRECT;
   wire t_by = take & (BYTE_RD | BYTE_WR);
   wire t_rd = take & ~BYTE_WR & BYTE_RD;
   wire t_bw = take & ~BYTE_WR & ~BYTE_RD & BIT_WR;
   wire t_pg = take & BYTE_WR & (ACC_ADDR == 8'h91);
   wire alt_a = (ACC_ADDR >= 8'hB1 && ACC_ADDR <= 8'hB6) ||
                ACC_ADDR[7:1] == 7'h56;
   logic [7:0] addr_d, wd_d, mrg_q;
   logic alt_d, bv_q;
   logic [2:0] idx_q;
   always_ff @(posedge MCLK) begin
      addr_d <= ACC_ADDR;
      wd_d <= ACC_WDATA;
      alt_d <= alt_a;
      if (t_bw) begin
         idx_q <= ACC_ADDR[2:0];
         bv_q <= BIT_VAL;
      end
      if (PER_RD) begin
         mrg_q <= (PER_RDATA & ~(8'h01 << idx_q)) | (8'(bv_q) << idx_q);
      end
   end
   sequence s_rd_take;
      t_rd;
   endsequence
   sequence s_bit_take;
      t_bw;
   endsequence
   chk_read_walk: assert property (s_rd_take |=> BUSY ##1 RVALID && !BUSY)
      else $error("read answer timing wrong");
   chk_bit_walk: assert property (s_bit_take |=> PER_RD && BUSY &&
      PER_ADDR == {addr_d[7:3], 3'h0} ##1 PER_WR && !BUSY)
      else $error("bit write walk wrong");
   chk_bit_merge: assert property (PER_WR && $past(PER_RD) |->
      PER_WDATA == mrg_q) else $error("bit merge wrong");
   chk_direct_only: assert property (req && !BUSY &&
      (ACC_INDIRECT || !ACC_ADDR[7]) |=> !PER_RD && !PER_WR && !UNOCC_HIT)
      else $error("refused access reached space");
   chk_unocc_hit: assert property (t_by && (ACC_ADDR == 8'h84 ||
      PAGE_NOW && ACC_ADDR == 8'hFE) |=> UNOCC_HIT && !PER_RD && !PER_WR)
      else $error("unoccupied access wrong");
   chk_page_map: assert property (s_rd_take ##1 PER_RD |->
      PER_ADDR == addr_d && PER_ALT == (PAGE_NOW && alt_d))
      else $error("page mapping wrong");
   chk_key_guard: assert property (t_pg && !UNLOCKED |=> $stable(PAGE_NOW))
      else $error("locked page write took effect");
   chk_page_set: assert property (t_pg && UNLOCKED |=> PAGE_NOW == wd_d[0])
      else $error("page write not applied");
   chk_window_len: assert property ($rose(UNLOCKED) |-> ##4 !UNLOCKED)
      else $error("unlock window too long");
   chk_reset_page: assert property ($fell(RESET) |-> !PAGE_NOW && !UNLOCKED)
      else $error("reset state wrong");
endmodule
bind sfr_space_page_decoder sfr_decoder_props i_props (.MCLK(MCLK),
   .RESET(RESET), .ACC_ADDR(ACC_ADDR), .ACC_INDIRECT(ACC_INDIRECT),
   .BYTE_RD(BYTE_RD), .BYTE_WR(BYTE_WR), .BIT_RD(BIT_RD), .BIT_WR(BIT_WR),
   .BIT_VAL(BIT_VAL), .ACC_WDATA(ACC_WDATA), .PER_RDATA(PER_RDATA),
   .BUSY(BUSY), .RVALID(RVALID), .PER_RD(PER_RD), .PER_WR(PER_WR),
   .PER_ADDR(PER_ADDR), .PER_ALT(PER_ALT), .PER_WDATA(PER_WDATA),
   .PAGE_NOW(PAGE_NOW), .UNLOCKED(UNLOCKED), .UNOCC_HIT(UNOCC_HIT));

// [shared/sfr_page_pkg.sv]
package sfr_page_pkg;

   // Register space limits and fixed locations
   localparam logic [7:0] SFR_BASE = 8'h80;
   localparam logic [7:0] ADDR_PAGE_SEL = 8'h91;
   localparam logic [7:0] ADDR_KEY = 8'hC7;
   localparam logic [7:0] PAGE_SEL_RESET = 8'h00;
   localparam int PAGE_BIT = 0;
   localparam logic [2:0] BITABLE_LOW3 = 3'h0;
   localparam logic [7:0] READ_ZERO = 8'h00;

   // Timed-access key values
   localparam logic [7:0] KEY_FIRST = 8'hAA;
   localparam logic [7:0] KEY_SECOND = 8'h55;

   // Timing
   localparam int CLK_PERIOD_NS = 4;
   localparam int TA_WINDOW_NS = 16;
   localparam int TA_WINDOW_RAW = TA_WINDOW_NS / CLK_PERIOD_NS;
   localparam int TA_WINDOW_CYC = (TA_WINDOW_RAW < 1) ? 1 : TA_WINDOW_RAW;
   localparam int TA_CNT_W = 3;

   typedef enum logic [1:0] {
      ST_IDLE = 2'b01,
      ST_FETCH = 2'b10
   } access_state_t;

   typedef enum logic [2:0] {
      TA_LOCKED = 3'b001,
      TA_HALF = 3'b010,
      TA_OPEN = 3'b100
   } ta_state_t;

   // Bit access exists only where the low three address bits are zero
   function automatic logic bit_capable(input logic [7:0] a);
      return a[2:0] == BITABLE_LOW3;
   endfunction

   // Locations whose meaning changes on page 1
   function automatic logic page1_alt(input logic [7:0] a);
      case (a)
         8'hB1, 8'hB2, 8'hB3, 8'hB4, 8'hB5, 8'hB6,
         8'hAC, 8'hAD: return 1'b1;
         default: return 1'b0;
      endcase
   endfunction

   // Unoccupied holes, FE/FF only on page 1
   function automatic logic unoccupied(input logic [7:0] a,
                                       input logic page);
      case (a)
         8'h84, 8'h85, 8'hA1, 8'h9D, 8'h9E, 8'hF1,
         8'hFD: return 1'b1;
         8'hFE, 8'hFF: return page;
         default: return 1'b0;
      endcase
   endfunction

endpackage

// [verilog/sfr_space_map.sv]
`timescale 1ns/1ps
module sfr_space_map (
   input wire logic [7:0] addr,
   input wire logic page,
   output logic ext_hit,
   output logic alt,
   output logic hit_page,
   output logic hit_key,
   output logic unocc
);

   assign hit_page = addr == sfr_page_pkg::ADDR_PAGE_SEL;
   assign hit_key = addr == sfr_page_pkg::ADDR_KEY;
   assign unocc = sfr_page_pkg::unoccupied(addr, page);
   assign alt = page & sfr_page_pkg::page1_alt(addr);
   // Shared locations decode identically on both pages
   assign ext_hit = ~hit_page & ~hit_key & ~unocc;

endmodule

// [verilog/sfr_space_page_decoder.sv]
`timescale 1ns/1ps
module sfr_space_page_decoder (
   input wire logic MCLK,
   input wire logic RESET,
   input wire logic [7:0] ACC_ADDR,
   input wire logic ACC_INDIRECT,
   input wire logic BYTE_RD,
   input wire logic BYTE_WR,
   input wire logic BIT_RD,
   input wire logic BIT_WR,
   input wire logic BIT_VAL,
   input wire logic [7:0] ACC_WDATA,
   input wire logic [7:0] PER_RDATA,
   output logic BUSY,
   output logic [7:0] RDATA,
   output logic RBIT,
   output logic RVALID,
   output logic PER_RD,
   output logic PER_WR,
   output logic [7:0] PER_ADDR,
   output logic PER_ALT,
   output logic [7:0] PER_WDATA,
   output logic PAGE_NOW,
   output logic UNLOCKED,
   output logic UNOCC_HIT
);

   ////////////////////////////////////////////////////////////////////
   // Declarations
   ////////////////////////////////////////////////////////////////////

   sfr_page_pkg::access_state_t state_r;
   sfr_page_pkg::access_state_t state_nxt;

   logic page_r;
   logic busy_r;
   logic [7:0] rdata_r;
   logic rbit_r;
   logic rvalid_r;
   logic per_rd_r;
   logic per_wr_r;
   logic [7:0] per_addr_r;
   logic per_alt_r;
   logic [7:0] per_wdata_r;
   logic unocc_r;

   logic [2:0] bitsel_r;
   logic bitval_r;
   logic op_bitwr_r;
   logic op_ext_r;
   logic op_page_r;
   logic op_unocc_r;

   logic any_byte;
   logic any_bit;
   logic any_req;
   logic is_bit;
   logic [7:0] byte_addr;
   logic in_space;
   logic bit_ok;
   logic take;
   logic take_wr;
   logic take_rd;
   logic ext_hit;
   logic alt;
   logic hit_page;
   logic hit_key;
   logic unocc;
   logic key_wr;
   logic page_wr;
   logic ta_open;
   logic [7:0] page_view;
   logic [7:0] fetched;
   logic [7:0] merged;

   ////////////////////////////////////////////////////////////////////
   // Helpers
   ////////////////////////////////////////////////////////////////////

   function automatic logic [7:0] put_bit(input logic [7:0] v,
                                          input logic [2:0] i,
                                          input logic b);
      logic [7:0] r;
      r = v;
      r[i] = b;
      return r;
   endfunction

   ////////////////////////////////////////////////////////////////////
   // Request decode
   ////////////////////////////////////////////////////////////////////

   assign any_byte = BYTE_RD | BYTE_WR;
   assign any_bit = BIT_RD | BIT_WR;
   assign any_req = any_byte | any_bit;

   // Byte access wins over a bit access offered together
   assign is_bit = any_bit & ~any_byte;

   // Bit address 80h..FFh names bit [2:0] of byte {a[7:3],000}
   assign byte_addr = is_bit ? {ACC_ADDR[7:3], 3'h0} : ACC_ADDR;

   // Indirect access to the upper half goes to RAM, never here
   assign in_space = ACC_ADDR[7] & ~ACC_INDIRECT;

   // Bit path only ever names 0h/8h registers
   assign bit_ok = ~is_bit | sfr_page_pkg::bit_capable(byte_addr);

   assign take = (state_r == sfr_page_pkg::ST_IDLE) & any_req &
                 in_space & bit_ok;
   assign take_wr = take & BYTE_WR;
   assign take_rd = take & ~BYTE_WR;

   sfr_space_map map_u (
      .addr(byte_addr),
      .page(page_r),
      .ext_hit(ext_hit),
      .alt(alt),
      .hit_page(hit_page),
      .hit_key(hit_key),
      .unocc(unocc)
   );

   ////////////////////////////////////////////////////////////////////
   // Timed-access key and page select
   ////////////////////////////////////////////////////////////////////

   assign key_wr = take_wr & hit_key;

   // Locked writes to the page register are dropped silently
   assign page_wr = take_wr & hit_page & ta_open;

   ta_key_gate ta_u (
      .clk(MCLK),
      .rst(RESET),
      .key_wr(key_wr),
      .key_data(ACC_WDATA),
      .consume(page_wr),
      .open_r(ta_open)
   );

   // Upper seven bits reserved, read as zero
   assign page_view = {7'h00, page_r};

   always_ff @(posedge MCLK) begin
      if (RESET) begin
         page_r <= sfr_page_pkg::PAGE_SEL_RESET[sfr_page_pkg::PAGE_BIT];
      end else if (page_wr) begin
         page_r <= ACC_WDATA[sfr_page_pkg::PAGE_BIT];
      end
   end

   ////////////////////////////////////////////////////////////////////
   // Access sequencer
   ////////////////////////////////////////////////////////////////////

   // Holes read as zero and never strobe a peripheral
   assign fetched = op_page_r ? page_view :
                    op_ext_r ? PER_RDATA :
                    sfr_page_pkg::READ_ZERO;

   // Single-bit write keeps the other seven bits
   assign merged = put_bit(fetched, bitsel_r, bitval_r);

   always_comb begin
      state_nxt = state_r;
      case (state_r)
         sfr_page_pkg::ST_IDLE: begin
            if (take_rd) begin
               state_nxt = sfr_page_pkg::ST_FETCH;
            end
         end
         sfr_page_pkg::ST_FETCH: begin
            state_nxt = sfr_page_pkg::ST_IDLE;
         end
         default: begin
            state_nxt = sfr_page_pkg::ST_IDLE;
         end
      endcase
   end

   always_ff @(posedge MCLK) begin
      if (RESET) begin
         state_r <= sfr_page_pkg::ST_IDLE;
         busy_r <= 1'b0;
      end else begin
         state_r <= state_nxt;
         busy_r <= state_nxt != sfr_page_pkg::ST_IDLE;
      end
   end

   // Operation context captured when a request is taken
   always_ff @(posedge MCLK) begin
      if (RESET) begin
         bitsel_r <= 3'h0;
         bitval_r <= 1'b0;
         op_bitwr_r <= 1'b0;
         op_ext_r <= 1'b0;
         op_page_r <= 1'b0;
         op_unocc_r <= 1'b0;
      end else if (take) begin
         bitsel_r <= ACC_ADDR[2:0];
         bitval_r <= BIT_VAL;
         op_bitwr_r <= is_bit & BIT_WR;
         op_ext_r <= ext_hit;
         op_page_r <= hit_page;
         op_unocc_r <= unocc;
      end
   end

   ////////////////////////////////////////////////////////////////////
   // Peripheral strobes
   ////////////////////////////////////////////////////////////////////

   always_ff @(posedge MCLK) begin
      if (RESET) begin
         per_rd_r <= 1'b0;
         per_wr_r <= 1'b0;
         per_addr_r <= 8'h00;
         per_alt_r <= 1'b0;
         per_wdata_r <= 8'h00;
         unocc_r <= 1'b0;
      end else begin
         per_rd_r <= 1'b0;
         per_wr_r <= 1'b0;
         unocc_r <= 1'b0;
         if (take) begin
            per_addr_r <= byte_addr;
            per_alt_r <= alt;
            per_rd_r <= ~BYTE_WR & ext_hit;
            per_wr_r <= BYTE_WR & ext_hit;
            per_wdata_r <= ACC_WDATA;
            unocc_r <= unocc;
         end else if (state_r == sfr_page_pkg::ST_FETCH && op_bitwr_r) begin
            per_wr_r <= op_ext_r;
            per_wdata_r <= merged;
         end
      end
   end

   ////////////////////////////////////////////////////////////////////
   // Read return
   ////////////////////////////////////////////////////////////////////

   always_ff @(posedge MCLK) begin
      if (RESET) begin
         rdata_r <= 8'h00;
         rbit_r <= 1'b0;
         rvalid_r <= 1'b0;
      end else begin
         rvalid_r <= 1'b0;
         if (state_r == sfr_page_pkg::ST_FETCH && !op_bitwr_r) begin
            rdata_r <= fetched;
            rbit_r <= fetched[bitsel_r];
            rvalid_r <= 1'b1;
         end
      end
   end

   ////////////////////////////////////////////////////////////////////
   // Outputs
   ////////////////////////////////////////////////////////////////////

   assign BUSY = busy_r;
   assign RDATA = rdata_r;
   assign RBIT = rbit_r;
   assign RVALID = rvalid_r;
   assign PER_RD = per_rd_r;
   assign PER_WR = per_wr_r;
   assign PER_ADDR = per_addr_r;
   assign PER_ALT = per_alt_r;
   assign PER_WDATA = per_wdata_r;
   assign PAGE_NOW = page_r;
   assign UNLOCKED = ta_open;
   assign UNOCC_HIT = unocc_r;

endmodule

// [verilog/ta_key_gate.sv]
`timescale 1ns/1ps
module ta_key_gate (
   input wire logic clk,
   input wire logic rst,
   input wire logic key_wr,
   input wire logic [7:0] key_data,
   input wire logic consume,
   output logic open_r
);

   sfr_page_pkg::ta_state_t state_r;
   sfr_page_pkg::ta_state_t state_nxt;
   logic [sfr_page_pkg::TA_CNT_W-1:0] cnt_r;
   logic [sfr_page_pkg::TA_CNT_W-1:0] cnt_nxt;
   logic is_first;
   logic is_second;

   assign is_first = key_data == sfr_page_pkg::KEY_FIRST;
   assign is_second = key_data == sfr_page_pkg::KEY_SECOND;

   always_comb begin
      state_nxt = state_r;
      cnt_nxt = cnt_r;
      case (state_r)
         sfr_page_pkg::TA_LOCKED: begin
            if (key_wr && is_first) begin
               state_nxt = sfr_page_pkg::TA_HALF;
            end
         end
         sfr_page_pkg::TA_HALF: begin
            if (key_wr && is_second) begin
               state_nxt = sfr_page_pkg::TA_OPEN;
               cnt_nxt = sfr_page_pkg::TA_CNT_W'(
                  sfr_page_pkg::TA_WINDOW_CYC - 1);
            end else if (key_wr && !is_first) begin
               state_nxt = sfr_page_pkg::TA_LOCKED;
            end
         end
         sfr_page_pkg::TA_OPEN: begin
            // Closes on first protected write or on window end
            if (consume || cnt_r == '0) begin
               state_nxt = sfr_page_pkg::TA_LOCKED;
            end else begin
               cnt_nxt = cnt_r - 1'b1;
            end
         end
         default: begin
            state_nxt = sfr_page_pkg::TA_LOCKED;
         end
      endcase
   end

   always_ff @(posedge clk) begin
      if (rst) begin
         state_r <= sfr_page_pkg::TA_LOCKED;
         cnt_r <= '0;
         open_r <= 1'b0;
      end else begin
         state_r <= state_nxt;
         cnt_r <= cnt_nxt;
         open_r <= state_nxt == sfr_page_pkg::TA_OPEN;
      end
   end

endmodule
